/* File: hdl/dbg_byte_cmp.sv */
// Purpose: Compares one stored ID byte with one supplied ID byte.
// Assumes: Both bytes are valid in the same cycle.
// Notes: Registered result, one cycle after the compare strobe.
`timescale 1ns/100ps
`default_nettype none
module dbg_byte_cmp
(
   input wire logic clk,
   input wire logic rst,
   input wire logic cmp_go,
   input wire logic [7:0] stored,
   input wire logic [7:0] supplied,
   output logic hit_r,
   output logic done_r
);
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         hit_r <= 1'b0;
         done_r <= 1'b0;
      end
      else
      begin
         done_r <= cmp_go;
         hit_r <= cmp_go && (stored == supplied);
      end
   end
endmodule : dbg_byte_cmp
`default_nettype wire

/* File: hdl/dbg_gate_pkg.sv */
// Purpose: Constants shared by the debug security gate.
// Assumes: Flash bytes are fetched one at a time over a simple read port.
// Notes: Overview of operation follows.
// Overview of operation
// - Debug session is authenticated against ten flash bytes at 0x70 to 0x79.
// - A full match releases protection, enabling flash readout and emulator operation.
// - Bit 7 of byte 0x79 is the emulator enable flag, one enables.
// - Debugging stays refused when the enable flag is clear, even on match.
// - Pin or internal reset during run makes break behaviour unreliable.
// - Pin reset still reinitialises port buffers even while reset is masked.
// - Flash software breakpoints suspend on target or watchdog reset, rearm on hardware/forced break.
// - While halted at a break, pin reset is masked from processor and peripherals.
// - Reset coinciding with monitor flash read may leave an incomplete reset.
package dbg_gate_pkg;
   localparam int ID_BYTES = 10;
   localparam logic [23:0] ID_BASE_ADDR = 24'h000070;
   localparam logic [23:0] ID_LAST_ADDR = 24'h000079;
   localparam int EN_FLAG_BIT = 7;
   localparam logic [3:0] LAST_IDX = 4'h9;
endpackage : dbg_gate_pkg

/* File: hdl/dbg_security_gate.sv */
// Purpose: Gates debug access behind a ten-byte flash-held security code.
// Assumes: Flash read answers in the cycle after FLASH_RD; emulator supplies bytes ascending.
// Notes: Reset masking and breakpoint suspension are modelled as simple status levels.
`timescale 1ns/100ps
`default_nettype none
module dbg_security_gate
(
   input wire logic CLK,
   input wire logic RST,
   input wire logic AUTH_START,
   input wire logic ID_VALID,
   input wire logic [7:0] ID_BYTE,
   output logic ID_READY,
   output logic FLASH_RD,
   output logic [23:0] FLASH_ADDR,
   input wire logic [7:0] FLASH_DATA,
   output logic AUTH_DONE,
   output logic UNLOCKED,
   output logic PIN_RESET_IN,
   input wire logic PIN_RESET,
   input wire logic INT_RESET,
   input wire logic WDT_RESET,
   input wire logic BREAK_HALT,
   input wire logic HW_BREAK,
   input wire logic MON_READ,
   output logic CORE_RESET,
   output logic PORT_RESET,
   output logic SWBP_ARMED,
   output logic BREAK_UNSURE
);
   import dbg_gate_pkg::*;

   typedef enum logic [1:0] {S_IDLE, S_FETCH, S_CMP, S_DONE} state_e;
   state_e state_r;
   logic [3:0] idx_r;
   logic all_hit_r;
   logic en_flag_r;
   logic [7:0] held_r;
   logic unlocked_r;
   logic done_r;
   logic cmp_go;
   logic hit;
   logic cmp_done;
   logic take;

   // Pin-reset wire is passed straight out for the bench to observe.
   assign PIN_RESET_IN = PIN_RESET;
   assign ID_READY = (state_r == S_FETCH);
   assign take = ID_READY && ID_VALID;
   assign FLASH_ADDR = ID_BASE_ADDR + {20'h00000, idx_r};
   assign FLASH_RD = take;
   assign cmp_go = (state_r == S_CMP);
   assign AUTH_DONE = done_r;
   assign UNLOCKED = unlocked_r;

   dbg_byte_cmp u_cmp
   (
      .clk(CLK),
      .rst(RST),
      .cmp_go(cmp_go),
      .stored(FLASH_DATA),
      .supplied(held_r),
      .hit_r(hit),
      .done_r(cmp_done)
   );

   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         state_r <= S_IDLE;
         idx_r <= 4'h0;
         held_r <= 8'h00;
         done_r <= 1'b0;
      end
      else
      begin
         done_r <= 1'b0;
         case (state_r)
            S_IDLE:
            begin
               idx_r <= 4'h0;
               if (AUTH_START)
                  state_r <= S_FETCH;
            end
            S_FETCH:
            begin
               if (take)
               begin
                  held_r <= ID_BYTE;
                  state_r <= S_CMP;
               end
            end
            S_CMP:
            begin
               // The flash byte arrives now; the compare result lands next cycle.
               if (idx_r == LAST_IDX)
               begin
                  state_r <= S_DONE;
               end
               else
               begin
                  idx_r <= idx_r + 4'h1;
                  state_r <= S_FETCH;
               end
            end
            S_DONE:
            begin
               done_r <= 1'b1;
               state_r <= S_IDLE;
            end
            default:
               state_r <= S_IDLE;
         endcase
      end
   end

   // Running AND of every byte compare; one miss sticks until the next start.
   always_ff @(posedge CLK)
   begin
      if (RST)
         all_hit_r <= 1'b0;
      else if (state_r == S_IDLE && AUTH_START)
         all_hit_r <= 1'b1;
      else if (cmp_done && !hit)
         all_hit_r <= 1'b0;
   end

   always_ff @(posedge CLK)
   begin
      if (RST)
         en_flag_r <= 1'b0;
      else if (cmp_go && idx_r == LAST_IDX)
         en_flag_r <= FLASH_DATA[EN_FLAG_BIT];
   end

   always_ff @(posedge CLK)
   begin
      if (RST)
         unlocked_r <= 1'b0;
      else if (state_r == S_IDLE && AUTH_START)
         unlocked_r <= 1'b0;
      else if (state_r == S_DONE)
         unlocked_r <= all_hit_r && !(cmp_done && !hit) && en_flag_r;
   end

   // Pin reset is blocked from the core while halted; ports still follow it.
   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         CORE_RESET <= 1'b0;
         PORT_RESET <= 1'b0;
      end
      else
      begin
         CORE_RESET <= (PIN_RESET && !BREAK_HALT) || INT_RESET || WDT_RESET;
         PORT_RESET <= PIN_RESET;
      end
   end

   always_ff @(posedge CLK)
   begin
      if (RST)
         SWBP_ARMED <= 1'b1;
      else if (HW_BREAK)
         SWBP_ARMED <= 1'b1;
      else if ((PIN_RESET && !BREAK_HALT) || WDT_RESET)
         SWBP_ARMED <= 1'b0;
   end

   // Sticky warning: break state or reset may be untrustworthy after these events.
   always_ff @(posedge CLK)
   begin
      if (RST)
         BREAK_UNSURE <= 1'b0;
      else if (HW_BREAK)
         BREAK_UNSURE <= 1'b0;
      else if (!BREAK_HALT && (PIN_RESET || INT_RESET))
         BREAK_UNSURE <= 1'b1;
      else if (MON_READ && (PIN_RESET || INT_RESET))
         BREAK_UNSURE <= 1'b1;
   end

   property p_halt_mask;
      @(posedge CLK) disable iff (RST)
      (PIN_RESET && BREAK_HALT && !INT_RESET && !WDT_RESET) |=> !CORE_RESET;
   endproperty
   a_halt_mask: assert property (p_halt_mask) else $error("Core reset during break halt.");

   property p_port_reset;
      @(posedge CLK) disable iff (RST)
      PIN_RESET |=> PORT_RESET;
   endproperty
   a_port_reset: assert property (p_port_reset) else $error("Port reset missed.");

   property p_wdt_swbp;
      @(posedge CLK) disable iff (RST)
      (WDT_RESET && !HW_BREAK) |=> !SWBP_ARMED;
   endproperty
   a_wdt_swbp: assert property (p_wdt_swbp) else $error("Breakpoint not suspended.");

   property p_rearm;
      @(posedge CLK) disable iff (RST)
      HW_BREAK |=> SWBP_ARMED;
   endproperty
   a_rearm: assert property (p_rearm) else $error("Breakpoint not rearmed.");

   property p_unlock_needs_flag;
      @(posedge CLK) disable iff (RST)
      $rose(unlocked_r) |-> $past(en_flag_r);
   endproperty
   a_unlock_needs_flag: assert property (p_unlock_needs_flag) else $error("Unlock with flag clear.");

   property p_miss_locks;
      @(posedge CLK) disable iff (RST)
      (cmp_done && !hit) |-> ##[0:40] (AUTH_DONE && !UNLOCKED) or (state_r == S_IDLE && AUTH_START);
   endproperty
   a_miss_locks: assert property (p_miss_locks) else $error("Mismatch did not lock.");

   property p_done_sync;
      @(posedge CLK) disable iff (RST)
      (state_r == S_DONE) |=> (AUTH_DONE && UNLOCKED == (all_hit_r && en_flag_r));
   endproperty
   a_done_sync: assert property (p_done_sync) else $error("Unlock result wrong.");

   property p_addr_range;
      @(posedge CLK) disable iff (RST)
      FLASH_RD |-> (FLASH_ADDR >= ID_BASE_ADDR && FLASH_ADDR <= ID_LAST_ADDR);
   endproperty
   a_addr_range: assert property (p_addr_range) else $error("Flash address out of range.");

   property p_unsure;
      @(posedge CLK) disable iff (RST)
      (!BREAK_HALT && INT_RESET && !HW_BREAK) |=> BREAK_UNSURE;
   endproperty
   a_unsure: assert property (p_unsure) else $error("Break warning missed.");
endmodule : dbg_security_gate
`default_nettype wire

/* File: tb/debug_security_id_gate_tb.sv */
// Purpose: Self-checking bench for the debug security gate.
// Assumes: Inputs change 1 ns after the rising edge.
// Notes: Byte 0 of a code sits in bits 7:0.
`timescale 1ns/100ps
`default_nettype none
module debug_security_id_gate_tb;
   logic clk = 0, rst = 1, auth_start = 0, id_valid = 0, pin_reset = 0, int_reset = 0;
   logic wdt_reset = 0, break_halt = 0, hw_break = 0, mon_read = 0;
   logic [7:0] id_byte = 8'h00, flash_data;
   logic id_ready, flash_rd, auth_done, unlocked, pin_reset_in, core_reset, port_reset, swbp_armed, break_unsure;
   logic [23:0] flash_addr;
   logic [79:0] image = 80'hd423f1debc9a78563412;
   int err_total = 0, n_tests = 0;
   always #2.5 clk = ~clk;
   dbg_security_gate dut_u (.CLK(clk), .RST(rst), .AUTH_START(auth_start), .ID_VALID(id_valid),
      .ID_BYTE(id_byte), .ID_READY(id_ready), .FLASH_RD(flash_rd), .FLASH_ADDR(flash_addr),
      .FLASH_DATA(flash_data), .AUTH_DONE(auth_done), .UNLOCKED(unlocked), .PIN_RESET_IN(pin_reset_in),
      .PIN_RESET(pin_reset), .INT_RESET(int_reset), .WDT_RESET(wdt_reset), .BREAK_HALT(break_halt),
      .HW_BREAK(hw_break), .MON_READ(mon_read), .CORE_RESET(core_reset), .PORT_RESET(port_reset),
      .SWBP_ARMED(swbp_armed), .BREAK_UNSURE(break_unsure));
   id_flash_model flash_u (.clk(clk), .rd(flash_rd), .addr(flash_addr), .image(image), .data(flash_data));
   task chk(input logic [23:0] seen, input logic [23:0] exp, input string msg);
      n_tests++;
      if (seen !== exp)
      begin
         err_total++;
         $display("CHECK FAILED t=%0t %s", $time, msg);
      end
   endtask : chk
   task step;
      @(posedge clk);
      #1;
   endtask : step
   // The emulator side sends all ten bytes in ascending order, one take at a time.
   task auth(input logic [79:0] code, input logic unlock_exp);
      int n;
      auth_start = 1;
      step();
      auth_start = 0;
      for (int k = 0; k < 10; k++)
      begin
         n = 0;
         while (id_ready !== 1'b1 && n < 8)
         begin
            step();
            n++;
         end
         chk(24'(id_ready), 24'h1, "ready for byte");
         id_valid = 1;
         id_byte = code[k * 8 +: 8];
         #1;
         chk(flash_addr, 24'h000070 + 24'(k), "flash address");
         chk(24'(flash_rd), 24'h1, "flash read");
         step();
         id_valid = 0;
         chk(24'(id_ready), 24'h0, "no back to back take");
      end
      n = 0;
      while (auth_done !== 1'b1 && n < 8)
      begin
         step();
         n++;
      end
      chk(24'(auth_done), 24'h1, "done");
      chk(24'(unlocked), 24'(unlock_exp), "unlock");
   endtask : auth
   task sc_match;
      auth(image, 1);
   endtask : sc_match
   // A reset in mid-run must drop an earlier unlock and leave the gate idle.
   task sc_mid_reset;
      rst = 1;
      step();
      chk(24'({unlocked, auth_done, id_ready}), 24'h0, "mid-run reset");
      rst = 0;
   endtask : sc_mid_reset
   task sc_flag_clear;
      image[79] = 0;
      auth(image, 0);
      image[79] = 1;
   endtask : sc_flag_clear
   task sc_mismatch;
      auth(image ^ 80'h1, 0);
      auth(image ^ 80'h1 << 72, 0);
   endtask : sc_mismatch
   // Each case pulses its reset and break inputs for one cycle; registered effects show one cycle late.
   task rst_case(input logic [4:0] drv, input logic [3:0] e, input logic [3:0] m, input string msg);
      {break_halt, pin_reset, int_reset, wdt_reset, hw_break} = drv;
      #1;
      chk(24'(pin_reset_in), 24'(drv[3]), "pin copy");
      step();
      chk(24'({core_reset, port_reset, swbp_armed, break_unsure} & m), 24'(e & m), msg);
      {break_halt, pin_reset, int_reset, wdt_reset, hw_break} = 5'h00;
      // One quiet edge keeps the next case from redriving a source in the same time step.
      step();
   endtask : rst_case
   task sc_resets;
      rst_case(5'h18, 4'h6, 4'he, "halt masks pin");
      rst_case(5'h08, 4'hd, 4'hf, "pin in run");
      rst_case(5'h01, 4'h2, 4'hf, "break rearms");
      mon_read = 1;
      rst_case(5'h18, 4'h7, 4'hf, "monitor read reset");
      mon_read = 0;
      rst_case(5'h01, 4'h2, 4'hf, "break clears warning");
      rst_case(5'h02, 4'h8, 4'he, "watchdog");
      rst_case(5'h04, 4'h9, 4'hd, "internal");
   endtask : sc_resets
   task wrap_up;
      $display("errors %0d of %0d checks", err_total, n_tests);
      if (err_total == 0 && n_tests > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : wrap_up
   initial
   begin
      repeat (4) step();
      rst = 0;
      chk(24'({swbp_armed, unlocked, auth_done, id_ready, core_reset, port_reset, break_unsure}), 24'h40,
         "reset values");
      sc_match();
      sc_mid_reset();
      sc_flag_clear();
      sc_mismatch();
      sc_resets();
      wrap_up();
   end
   initial
   begin
      #20000;
      err_total++;
      wrap_up();
   end
endmodule : debug_security_id_gate_tb
`default_nettype wire

/* File: tb/id_flash_model.sv */
// Purpose: Flash model holding the stored ten-byte security code.
// Assumes: A read answers in the cycle after the request.
// Notes: Data drifts when not read, so stale bytes are never trusted.
`timescale 1ns/100ps
`default_nettype none
module id_flash_model
(
   input wire logic clk,
   input wire logic rd,
   input wire logic [23:0] addr,
   input wire logic [79:0] image,
   output logic [7:0] data
);
   always_ff @(posedge clk)
   begin
      if (rd && addr >= 24'h000070 && addr <= 24'h000079)
         data <= image[addr[3:0] * 8 +: 8];
      else
         data <= ~data;
   end
endmodule : id_flash_model
`default_nettype wire
